// File: dv/tasd_mem_model.sv
`timescale 1ns/100ps
// partner: on-chip buffer that logs every halfword write it receives
module tasd_mem_model
  import tasd_pkg::*;
#(
  parameter logic [31:0] SRC = 32'h0
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic mem_wr, // write strobe
  input wire logic [31:0] mem_addr, // halfword address
  input wire logic [31:0] mem_src, // transfer source
  input wire logic [15:0] mem_wdata, // halfword data
  output logic src_err // bad source or odd address seen
);
  logic [31:0] adr_q[$];
  logic [15:0] dat_q[$];
  // keep a log, not an array, so order and address slips stay visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_err <= 1'b0;
    end else if (mem_wr === 1'b1) begin
      adr_q.push_back(mem_addr);
      dat_q.push_back(mem_wdata);
      if (mem_src !== SRC || mem_addr[0] !== 1'b0) begin
        src_err <= 1'b1;
      end
    end
  end
endmodule

// File: dv/tasd_top_tb.sv
`timescale 1ns/100ps
module tasd_top_tb;
  import tasd_pkg::*;
  localparam logic [31:0] SRC = 32'h1000_0024;
  localparam logic [31:0] DST = 32'h0000_0100;
  // short normal conversion so the run stays brief
  localparam int CONV = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext_trig_pin = 1'b0;
  logic [15:0] comp_hi;
  logic [31:0] prdata, rdat, mem_addr, mem_src;
  logic pready, pslverr, rerr, mem_wr, irq, src_err;
  logic [9:0] dac_trial;
  logic [3:0] analog_ch_sel;
  logic [15:0] mem_wdata;
  logic [9:0] vin [16];
  int errors = 0;
  int check_count = 0;
  int base;

  tasd_top #(.CONV_CYC(CONV), .ABITS(32)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig_pin(ext_trig_pin), .comp_hi(comp_hi),
    .dac_trial(dac_trial), .analog_ch_sel(analog_ch_sel),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_src(mem_src),
    .mem_wdata(mem_wdata), .irq(irq));
  tasd_mem_model #(.SRC(SRC)) MEM (.pclk(pclk), .presetn(presetn),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_src(mem_src),
    .mem_wdata(mem_wdata), .src_err(src_err));

  always #5 pclk = ~pclk;
  // inputs sit half a code above their level, so equal trials never tie
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      comp_hi[i] = {vin[i], 1'b1} > {dac_trial, 1'b0};
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task final_report;
    $display("errors %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one apb transfer; the request holds until pready is sampled high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task wait_wr(input int n);
    for (int i = 0; i < 3000 && MEM.adr_q.size() < n; i++) begin
      @(posedge pclk);
    end
  endtask

  // converter irq and dma enables go in before the timer starts;
  // timer and dma are stopped first so a conversion still in flight cannot leak
  task arm(input logic [15:0] cnt, input logic [7:0] trig,
           input logic [31:0] ctrl, input logic [31:0] m1);
    xfer(1, TASD_OFF_TMR_CTRL, 32'h0);
    xfer(1, TASD_OFF_CTRL, 32'h0);
    xfer(1, TASD_OFF_TRIG_SEL, {24'h0, trig});
    xfer(1, TASD_OFF_SRC_ADDR, SRC);
    xfer(1, TASD_OFF_DST_ADDR, DST);
    xfer(1, TASD_OFF_COUNT, {16'h0, cnt});
    xfer(1, TASD_OFF_TMR_INTERVAL, 32'h9);
    xfer(1, TASD_OFF_ADC_MODE2, 32'h3);
    xfer(1, TASD_OFF_ADC_MODE1, m1);
    xfer(1, TASD_OFF_IRQ_CLR, 32'h7);
    xfer(1, TASD_OFF_CTRL, ctrl);
    xfer(1, TASD_OFF_TMR_CTRL, 32'h1);
  endtask

  task t_reset;
    xfer(0, TASD_OFF_COUNT, 32'h0);
    chk(rdat, {16'h0, TASD_COUNT_RST});
    xfer(0, TASD_OFF_TMR_INTERVAL, 32'h0);
    chk(rdat, {16'h0, TASD_INTERVAL_RST});
    xfer(0, 8'h40, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    xfer(0, TASD_OFF_IRQ_CLR, 32'h0);
    chk(rdat, 32'h0);
  endtask

  // 256 samples of channel one land in consecutive halfwords
  task t_run;
    base = MEM.adr_q.size();
    xfer(1, TASD_OFF_IRQ_EN, 32'h4);
    arm(16'hff, TASD_TRIG_ADC_DONE, 32'h3, 32'h3);
    chk(analog_ch_sel, 32'h1);
    for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge pclk);
    xfer(1, TASD_OFF_TMR_CTRL, 32'h0);
    xfer(1, TASD_OFF_CTRL, 32'h0);
    chk(irq, 1'b1);
    chk(MEM.adr_q.size() - base, 32'h100);
    for (int k = 0; k < 256; k++) begin
      chk(MEM.adr_q[base + k], DST + 2 * k);
      chk(MEM.dat_q[base + k], {6'h0, vin[1]});
    end
    chk(src_err, 1'b0);
    xfer(0, TASD_OFF_COUNT, 32'h0);
    chk(rdat, 32'hffff);
    xfer(1, TASD_OFF_IRQ_CLR, 32'h4);
    settle();
    chk(irq, 1'b0);
  endtask

  // count zero gives one transfer; masked done bit keeps irq low
  task t_mask;
    base = MEM.adr_q.size();
    vin[1] = 10'h15a;
    xfer(1, TASD_OFF_IRQ_EN, 32'h0);
    arm(16'h0, TASD_TRIG_ADC_DONE, 32'h3, 32'h3);
    wait_wr(base + 1);
    xfer(1, TASD_OFF_TMR_CTRL, 32'h0);
    chk(MEM.dat_q[base], 16'h015a);
    xfer(0, TASD_OFF_IRQ_STAT, 32'h0);
    chk(rdat[2], 1'b1);
    chk(irq, 1'b0);
    xfer(1, TASD_OFF_IRQ_EN, 32'h4);
    settle();
    chk(irq, 1'b1);
    xfer(1, TASD_OFF_IRQ_CLR, 32'h4);
    settle();
    chk(irq, 1'b0);
  endtask

  // pin-started conversion: trigger to write time lies near the nominal
  task t_speed(input logic [31:0] m1, input int lo, input int hi);
    int n;
    base = MEM.adr_q.size();
    arm(16'h5, TASD_TRIG_ADC_DONE, 32'h3, m1);
    @(posedge pclk);
    ext_trig_pin <= 1'b1;
    @(posedge pclk);
    ext_trig_pin <= 1'b0;
    n = 1;
    while (mem_wr !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
    settle();
    chk(MEM.dat_q[base], {6'h0, vin[1]});
    xfer(1, TASD_OFF_TMR_CTRL, 32'h0);
  endtask

  // blocked paths: no write may reach the buffer
  task t_blocked;
    logic [7:0] trig [4] = '{8'hac, 8'h00, 8'hac, 8'hac};
    logic [31:0] ctrl [4] = '{32'h2, 32'h3, 32'h3, 32'h3};
    logic [31:0] m1 [4] = '{32'h3, 32'h3, 32'h2, 32'h1};
    logic adc [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    for (int j = 0; j < 4; j++) begin
      base = MEM.adr_q.size();
      arm(16'h5, trig[j], ctrl[j], m1[j]);
      repeat (200) @(posedge pclk);
      xfer(0, TASD_OFF_IRQ_STAT, 32'h0);
      chk(rdat[1], adc[j]);
      chk(MEM.adr_q.size() - base, 32'h0);
    end
    // last setting waits on the pin: one pulse, one sample
    @(posedge pclk);
    ext_trig_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_trig_pin <= 1'b0;
    wait_wr(base + 1);
    chk(MEM.adr_q.size() - base, 32'h1);
    xfer(1, TASD_OFF_TMR_CTRL, 32'h0);
  endtask

  initial begin
    for (int i = 0; i < 16; i++) vin[i] = 10'h010 + 10'(i);
    vin[1] = 10'h2a5;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_run();
    t_mask();
    t_blocked();
    t_speed(32'h1, CONV, CONV + 8);
    t_speed(32'h5, TASD_HS_CONV_CYC - 8, TASD_HS_CONV_CYC + 8);
    final_report();
  end

  // run needs about 12000 cycles; the limit leaves wide margin
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    final_report();
  end
endmodule

// File: hw/tasd_pkg.sv
package tasd_pkg;
  // apb register byte offsets
  localparam logic [7:0] TASD_OFF_CTRL = 8'h00;
  localparam logic [7:0] TASD_OFF_ADC_MODE1 = 8'h04;
  localparam logic [7:0] TASD_OFF_ADC_MODE2 = 8'h08;
  localparam logic [7:0] TASD_OFF_TRIG_SEL = 8'h0c;
  localparam logic [7:0] TASD_OFF_SRC_ADDR = 8'h10;
  localparam logic [7:0] TASD_OFF_DST_ADDR = 8'h14;
  localparam logic [7:0] TASD_OFF_COUNT = 8'h18;
  localparam logic [7:0] TASD_OFF_TMR_INTERVAL = 8'h1c;
  localparam logic [7:0] TASD_OFF_TMR_CTRL = 8'h20;
  localparam logic [7:0] TASD_OFF_RESULT = 8'h24;
  localparam logic [7:0] TASD_OFF_IRQ_STAT = 8'h28;
  localparam logic [7:0] TASD_OFF_IRQ_EN = 8'h2c;
  localparam logic [7:0] TASD_OFF_IRQ_CLR = 8'h30;
  // trigger select code that picks converter completion
  localparam logic [7:0] TASD_TRIG_ADC_DONE = 8'hac;
  // ctrl bits
  localparam int TASD_CTRL_DMA_EN = 0;
  localparam int TASD_CTRL_ADC_IRQ_EN = 1;
  // first mode register bits
  localparam int TASD_M1_RUN = 0;
  localparam int TASD_M1_TRIG_TMR = 1;
  localparam int TASD_M1_HIGH_SPEED = 2;
  // second mode register: bit0 selects timer2 compare as trigger
  localparam int TASD_M2_TMR_TRIG = 0;
  // interrupt status bits
  localparam int TASD_IRQ_TMR = 0;
  localparam int TASD_IRQ_ADC = 1;
  localparam int TASD_IRQ_DMA_DONE = 2;
  // reset values
  localparam logic [15:0] TASD_COUNT_RST = 16'hffff;
  localparam logic [15:0] TASD_INTERVAL_RST = 16'hffff;
  // timing: normal conversion time and clock rate
  localparam real TASD_CONV_TIME_US = 20.7;
  localparam real TASD_CLK_MHZ = 100.0;
  localparam int TASD_CONV_CYC = int'(TASD_CONV_TIME_US * TASD_CLK_MHZ);
  localparam int TASD_HS_CONV_CYC = 64;
  localparam int TASD_TMR_PRESCALE = 4;
  localparam int TASD_ADC_BITS = 10;
  localparam int TASD_CHAN_BITS = 4;
  // converter sequencer states
  typedef enum logic [2:0] {
    TASD_ADC_IDLE = 3'b001,
    TASD_ADC_CONV = 3'b010,
    TASD_ADC_DONE = 3'b100
  } tasd_adc_st_t;
endpackage

// File: hw/tasd_sar.sv
`timescale 1ns/100ps
// successive approximation core: one bit per step, msb first
module tasd_sar
  import tasd_pkg::*;
#(
  parameter int BITS = TASD_ADC_BITS
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic step, // advance one bit
  input wire logic clear, // begin new conversion
  input wire logic comp_hi, // comparator: input above trial
  output logic [BITS-1:0] trial, // current trial value
  output logic finished // all bits decided
);
  logic [BITS-1:0] trial_r, trial_nxt;
  logic [BITS-1:0] mask_r, mask_nxt;

  // keep or drop the trial bit, then try the next lower one
  always_comb begin
    trial_nxt = trial_r;
    mask_nxt = mask_r;
    if (clear) begin
      mask_nxt = {1'b1, {(BITS-1){1'b0}}};
      trial_nxt = {1'b1, {(BITS-1){1'b0}}};
    end else if (step && mask_r != '0) begin
      if (!comp_hi) begin
        trial_nxt = trial_r & ~mask_r;
      end
      mask_nxt = mask_r >> 1;
      trial_nxt = trial_nxt | (mask_r >> 1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial_r <= '0;
      mask_r <= '0;
    end else begin
      trial_r <= trial_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign trial = trial_r;
  assign finished = (mask_r == '0);
endmodule

// File: hw/tasd_top.sv
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - trigger select code ac makes converter completion start dma
// - each timer 2 compare event starts one conversion
// - each conversion completion moves one result to memory
// - count decrements per transfer; done when it wraps to minus one
// - source address fixed, destination advances after each transfer
// - first mode register has run/stop and pin/timer trigger choice
// - high speed bit clear selects normal 20.7 us conversion
// - second mode register selects timer 2 compare as trigger
// - only the selected analog channel is converted
// - converter stop ends conversions and completion events
// - stopped dma performs no transfers despite triggers
// - 16-bit timer counts prescaled clock, fires and restarts
// - adc irq, dma and timer enables together start sampling
// - result is 10 bits by successive approximation, 16 channels
module tasd_top
  import tasd_pkg::*;
#(
  parameter int CONV_CYC = TASD_CONV_CYC,
  parameter int ABITS = 32
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic ext_trig_pin, // external conversion trigger
  input wire logic [15:0] comp_hi, // per-channel comparator
  output logic [TASD_ADC_BITS-1:0] dac_trial, // trial to comparator
  output logic [TASD_CHAN_BITS-1:0] analog_ch_sel, // muxed channel
  output logic mem_wr, // memory write strobe
  output logic [ABITS-1:0] mem_addr, // memory address
  output logic [ABITS-1:0] mem_src, // source address of transfer
  output logic [15:0] mem_wdata, // halfword to memory
  output logic irq // level interrupt
);
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [2:0] mode1_r, mode1_nxt;
  logic [TASD_CHAN_BITS:0] mode2_r, mode2_nxt;
  logic [7:0] trig_r, trig_nxt;
  logic [ABITS-1:0] src_r, src_nxt, dst_r, dst_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] ival_r, ival_nxt, tcnt_r, tcnt_nxt;
  logic [1:0] pre_r, pre_nxt;
  logic tmr_en_r, tmr_en_nxt;
  logic [TASD_ADC_BITS-1:0] res_r, res_nxt;
  logic [2:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pslverr_r, pslverr_nxt;
  logic mem_wr_r, mem_wr_nxt;
  logic [ABITS-1:0] maddr_r, maddr_nxt, msrc_r, msrc_nxt;
  logic [15:0] mdata_r, mdata_nxt;
  logic irq_r, irq_nxt;
  tasd_adc_st_t ast_r, ast_nxt;
  logic [15:0] ccnt_r, ccnt_nxt;
  logic tmr_evt, adc_evt, dma_done_evt, start_conv, xfer;
  logic sar_step, sar_clear, sar_fin, pin_d_r, pin_edge;
  logic [TASD_ADC_BITS-1:0] sar_trial;
  logic wr_acc, rd_acc, mapped;
  logic [15:0] step_cyc;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // address decode; unknown offsets answer with an error
  always_comb begin
    mapped = 1'b1;
    if (paddr == TASD_OFF_CTRL) prdata_nxt = {30'h0, ctrl_r};
    else if (paddr == TASD_OFF_ADC_MODE1) prdata_nxt = {29'h0, mode1_r};
    else if (paddr == TASD_OFF_ADC_MODE2) prdata_nxt = {27'h0, mode2_r};
    else if (paddr == TASD_OFF_TRIG_SEL) prdata_nxt = {24'h0, trig_r};
    else if (paddr == TASD_OFF_SRC_ADDR) prdata_nxt = 32'(src_r);
    else if (paddr == TASD_OFF_DST_ADDR) prdata_nxt = 32'(dst_r);
    else if (paddr == TASD_OFF_COUNT) prdata_nxt = {16'h0, cnt_r};
    else if (paddr == TASD_OFF_TMR_INTERVAL) prdata_nxt = {16'h0, ival_r};
    else if (paddr == TASD_OFF_TMR_CTRL) prdata_nxt = {31'h0, tmr_en_r};
    else if (paddr == TASD_OFF_RESULT) prdata_nxt = {22'h0, res_r};
    else if (paddr == TASD_OFF_IRQ_STAT) prdata_nxt = {29'h0, ist_r};
    else if (paddr == TASD_OFF_IRQ_EN) prdata_nxt = {29'h0, ien_r};
    else if (paddr == TASD_OFF_IRQ_CLR) prdata_nxt = 32'h0;
    else begin
      prdata_nxt = 32'h0;
      mapped = 1'b0;
    end
    if (!rd_acc || pready_r) prdata_nxt = prdata_r;
    pslverr_nxt = psel && penable && !pready_r && !mapped;
  end

  // timer: prescale by four, count to interval, fire and restart
  always_comb begin
    pre_nxt = pre_r;
    tcnt_nxt = tcnt_r;
    tmr_evt = 1'b0;
    if (tmr_en_r) begin
      pre_nxt = 2'(pre_r + 2'h1);
      if (pre_r == 2'(TASD_TMR_PRESCALE - 1)) begin
        if (tcnt_r == ival_r) begin
          tcnt_nxt = 16'h0;
          tmr_evt = 1'b1;
        end else begin
          tcnt_nxt = 16'(tcnt_r + 16'h1);
        end
      end
    end else begin
      pre_nxt = 2'h0;
      tcnt_nxt = 16'h0;
    end
  end

  // trigger source: timer 2 compare or rising edge of the pin
  assign pin_edge = ext_trig_pin && !pin_d_r;
  always_comb begin
    start_conv = 1'b0;
    if (mode1_r[TASD_M1_RUN]) begin
      if (mode1_r[TASD_M1_TRIG_TMR]) begin
        start_conv = tmr_evt && mode2_r[TASD_M2_TMR_TRIG];
      end else begin
        start_conv = pin_edge;
      end
    end
  end

  // per-bit step time; normal speed spreads the full conversion time
  assign step_cyc = mode1_r[TASD_M1_HIGH_SPEED] ?
    16'(TASD_HS_CONV_CYC / TASD_ADC_BITS) :
    16'(CONV_CYC / TASD_ADC_BITS);

  // converter sequencer; a new trigger during a conversion is ignored
  always_comb begin
    ast_nxt = ast_r;
    ccnt_nxt = ccnt_r;
    sar_step = 1'b0;
    sar_clear = 1'b0;
    adc_evt = 1'b0;
    res_nxt = res_r;
    case (ast_r)
      TASD_ADC_IDLE: begin
        if (start_conv) begin
          sar_clear = 1'b1;
          ccnt_nxt = 16'h0;
          ast_nxt = TASD_ADC_CONV;
        end
      end
      TASD_ADC_CONV: begin
        if (!mode1_r[TASD_M1_RUN]) begin
          ast_nxt = TASD_ADC_IDLE;
        end else if (sar_fin) begin
          ast_nxt = TASD_ADC_DONE;
        end else if (ccnt_r >= 16'(step_cyc - 16'h1)) begin
          sar_step = 1'b1;
          ccnt_nxt = 16'h0;
        end else begin
          ccnt_nxt = 16'(ccnt_r + 16'h1);
        end
      end
      TASD_ADC_DONE: begin
        res_nxt = sar_trial;
        adc_evt = ctrl_r[TASD_CTRL_ADC_IRQ_EN];
        ast_nxt = TASD_ADC_IDLE;
      end
      default: ast_nxt = TASD_ADC_IDLE;
    endcase
  end

  tasd_sar #(.BITS(TASD_ADC_BITS)) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .step(sar_step),
    .clear(sar_clear),
    .comp_hi(comp_hi[mode2_r[TASD_CHAN_BITS:1]]),
    .trial(sar_trial),
    .finished(sar_fin)
  );

  // dma: gated by trigger code and channel enable
  assign xfer = adc_evt && ctrl_r[TASD_CTRL_DMA_EN] &&
    trig_r == TASD_TRIG_ADC_DONE;
  assign dma_done_evt = xfer && cnt_r == 16'h0;

  // register writes and dma address/count updates
  always_comb begin
    ctrl_nxt = ctrl_r;
    mode1_nxt = mode1_r;
    mode2_nxt = mode2_r;
    trig_nxt = trig_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    cnt_nxt = cnt_r;
    ival_nxt = ival_r;
    tmr_en_nxt = tmr_en_r;
    ien_nxt = ien_r;
    ist_nxt = ist_r;
    mem_wr_nxt = 1'b0;
    maddr_nxt = maddr_r;
    msrc_nxt = msrc_r;
    mdata_nxt = mdata_r;
    if (wr_acc && !pready_r) begin
      if (paddr == TASD_OFF_CTRL) ctrl_nxt = pwdata[1:0];
      else if (paddr == TASD_OFF_ADC_MODE1) mode1_nxt = pwdata[2:0];
      else if (paddr == TASD_OFF_ADC_MODE2) mode2_nxt = pwdata[4:0];
      else if (paddr == TASD_OFF_TRIG_SEL) trig_nxt = pwdata[7:0];
      else if (paddr == TASD_OFF_SRC_ADDR) src_nxt = pwdata[ABITS-1:0];
      else if (paddr == TASD_OFF_DST_ADDR) dst_nxt = pwdata[ABITS-1:0];
      else if (paddr == TASD_OFF_COUNT) cnt_nxt = pwdata[15:0];
      else if (paddr == TASD_OFF_TMR_INTERVAL) ival_nxt = pwdata[15:0];
      else if (paddr == TASD_OFF_TMR_CTRL) tmr_en_nxt = pwdata[0];
      else if (paddr == TASD_OFF_IRQ_EN) ien_nxt = pwdata[2:0];
      else if (paddr == TASD_OFF_IRQ_CLR) ist_nxt = ist_r & ~pwdata[2:0];
    end
    // hardware transfer wins over a software write in the same cycle
    if (xfer) begin
      mem_wr_nxt = 1'b1;
      maddr_nxt = dst_r;
      msrc_nxt = src_r;
      mdata_nxt = {6'h0, res_nxt};
      dst_nxt = ABITS'(dst_r + ABITS'(2));
      cnt_nxt = 16'(cnt_r - 16'h1);
    end
    // set wins over clear
    if (tmr_evt) ist_nxt[TASD_IRQ_TMR] = 1'b1;
    if (adc_evt) ist_nxt[TASD_IRQ_ADC] = 1'b1;
    if (dma_done_evt) ist_nxt[TASD_IRQ_DMA_DONE] = 1'b1;
    irq_nxt = |(ist_nxt & ien_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 2'h0;
      mode1_r <= 3'h0;
      mode2_r <= 5'h0;
      trig_r <= 8'h0;
      src_r <= '0;
      dst_r <= '0;
      cnt_r <= TASD_COUNT_RST;
      ival_r <= TASD_INTERVAL_RST;
      tcnt_r <= 16'h0;
      pre_r <= 2'h0;
      tmr_en_r <= 1'b0;
      res_r <= '0;
      ist_r <= 3'h0;
      ien_r <= 3'h0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      mem_wr_r <= 1'b0;
      maddr_r <= '0;
      msrc_r <= '0;
      mdata_r <= 16'h0;
      irq_r <= 1'b0;
      ast_r <= TASD_ADC_IDLE;
      ccnt_r <= 16'h0;
      pin_d_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mode1_r <= mode1_nxt;
      mode2_r <= mode2_nxt;
      trig_r <= trig_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      cnt_r <= cnt_nxt;
      ival_r <= ival_nxt;
      tcnt_r <= tcnt_nxt;
      pre_r <= pre_nxt;
      tmr_en_r <= tmr_en_nxt;
      res_r <= res_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= psel && penable && !pready_r; // one wait state
      pslverr_r <= pslverr_nxt;
      mem_wr_r <= mem_wr_nxt;
      maddr_r <= maddr_nxt;
      msrc_r <= msrc_nxt;
      mdata_r <= mdata_nxt;
      irq_r <= irq_nxt;
      ast_r <= ast_nxt;
      ccnt_r <= ccnt_nxt;
      pin_d_r <= ext_trig_pin;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mem_wr = mem_wr_r;
  assign mem_addr = maddr_r;
  assign mem_src = msrc_r;
  assign mem_wdata = mdata_r;
  assign irq = irq_r;
  assign dac_trial = sar_trial;
  assign analog_ch_sel = mode2_r[TASD_CHAN_BITS:1];

  // a transfer follows a completion only under the proper gating
  a_xfer_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem_wr_nxt |-> ast_r == TASD_ADC_DONE && ctrl_r[TASD_CTRL_DMA_EN] &&
    trig_r == TASD_TRIG_ADC_DONE)
    else $error("transfer while dma stopped or wrong trigger");

  a_dst_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    xfer |=> dst_r == ABITS'($past(dst_r) + ABITS'(2)))
    else $error("destination did not advance by one halfword");

  a_cnt_dec: assert property (
    @(posedge pclk) disable iff (!presetn)
    xfer && !(wr_acc && !pready_r && paddr == TASD_OFF_COUNT)
    |=> cnt_r == 16'($past(cnt_r) - 16'h1))
    else $error("count did not decrement");

  a_done_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    dma_done_evt |=> cnt_r == 16'hffff && ist_r[TASD_IRQ_DMA_DONE])
    else $error("completion not at wrap to minus one");

  // a stopped converter leaves a running conversion and starts none
  a_stop_conv: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mode1_r[TASD_M1_RUN] |=> ast_r != TASD_ADC_CONV)
    else $error("conversion active while stopped");

  sequence s_trig;
    start_conv && ast_r == TASD_ADC_IDLE;
  endsequence
  sequence s_enter;
    ast_r == TASD_ADC_CONV;
  endsequence
  a_conv_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_trig |=> s_enter)
    else $error("trigger did not start conversion");

  a_src_fixed: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem_wr_r |-> mem_src == src_r || $past(wr_acc))
    else $error("source address moved");

  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == |(ist_r & ien_r))
    else $error("irq does not follow enabled status");

  a_halfword: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem_wr_r |-> mem_wdata[15:10] == 6'h0 && mem_wdata[9:0] == res_r)
    else $error("result not moved as one halfword");
endmodule
